// *** src/lld_pkg.sv ***
package lld_pkg;

  // ---------------------------------------------------------------
  // register map and field layout
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NUM_SRC  = 4;   // source 0 is the low detect

  localparam logic [ADDR_W-1:0] CHANNEL_MODE_REG_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] CHANNEL_STATUS_REG_OFS = 8'h04;

  // channel_mode_reg fields
  localparam int unsigned MODE_LDE_BIT  = 0;  // low_detect_enable
  localparam int unsigned MODE_IEN_LSB  = 1;  // int enables, one per source
  // channel status fields
  localparam int unsigned STAT_FLG_LSB  = 0;  // flags, bit 0 = low_detect_flag

  // values after reset
  localparam logic                 LDE_RST     = 1'b0;
  localparam logic [NUM_SRC-1:0]   IEN_RST     = 4'h0;
  localparam logic [NUM_SRC-1:0]   FLAG_RST    = 4'h0;
  localparam logic                 RX_IDLE_RST = 1'b1;  // recessive bus level
  localparam logic [DATA_W-1:0]    RDATA_RST   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              wrStb;
    logic              rdStb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } lld_bus_req_t;

endpackage : lld_pkg

// *** src/lld_flag_cell.sv ***
`timescale 1ns/1ps
`default_nettype none

module lld_flag_cell
  import lld_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // control
  input  wire logic setEvt,
  input  wire logic clrEvt,
  input  wire logic intEn,
  // state
  output var  logic flag,
  output var  logic riseReq
);

  logic flag_q;
  logic flag_d;

  // ---------------------------------------------------------------
  // sticky flag
  // ---------------------------------------------------------------
  // set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    flag_d = flag_q;
    if (clrEvt)
      flag_d = 1'b0;
    if (setEvt)
      flag_d = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  // only a 0 -> 1 change with the enable on counts as a new request
  assign riseReq = setEvt & ~flag_q & intEn;
  assign flag    = flag_q;

endmodule : lld_flag_cell

`default_nettype wire

// *** src/lld_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - enabled low detect flags rx falling edge
// - enabling while rx low flags at once
// - request when enabled flag rises to one
// - no request while another flag is set
module lld_top
  import lld_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // register port
  input  wire lld_bus_req_t       busReq,
  output var  logic [DATA_W-1:0]  rdData,
  // lin side
  input  wire logic               linRxInput,
  // other channel sources, one-cycle event pulses
  input  wire logic [NUM_SRC-2:0] srcEvt,
  // interrupt side
  output var  logic               chanIntReq,
  output var  logic               irq
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hitReg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] ofs);
    hitReg = (a == ofs);
  endfunction : hitReg

  logic wrMode;
  logic wrStat;
  logic rdMode;
  logic rdStat;

  // decode shared by writes and reads
  always_comb
  begin
    wrMode = busReq.wrStb & hitReg(busReq.addr, CHANNEL_MODE_REG_OFS);
    wrStat = busReq.wrStb & hitReg(busReq.addr, CHANNEL_STATUS_REG_OFS);
    rdMode = busReq.rdStb & hitReg(busReq.addr, CHANNEL_MODE_REG_OFS);
    rdStat = busReq.rdStb & hitReg(busReq.addr, CHANNEL_STATUS_REG_OFS);
  end

  // ---------------------------------------------------------------
  // channel_mode_reg
  // ---------------------------------------------------------------
  logic               lowDetectEnable_q;
  logic               lowDetectEnable_d;
  logic [NUM_SRC-1:0] intEnable_q;
  logic [NUM_SRC-1:0] intEnable_d;

  always_comb
  begin
    lowDetectEnable_d = lowDetectEnable_q;
    intEnable_d       = intEnable_q;
    if (wrMode)
    begin
      lowDetectEnable_d = busReq.wrData[MODE_LDE_BIT];
      intEnable_d       = busReq.wrData[MODE_IEN_LSB +: NUM_SRC];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowDetectEnable_q <= LDE_RST;
      intEnable_q       <= IEN_RST;
    end
    else
    begin
      lowDetectEnable_q <= lowDetectEnable_d;
      intEnable_q       <= intEnable_d;
    end
  end

  // ---------------------------------------------------------------
  // low level detection
  // ---------------------------------------------------------------
  logic linRxPrev_q;
  logic linRxPrev_d;
  logic fallEdge;
  logic enableWhileLow;
  logic lowDetectSet;

  // previous level idles high so a bus held low from reset gives an edge in the first cycle
  always_comb
  begin
    linRxPrev_d    = linRxInput;
    fallEdge       = linRxPrev_q & ~linRxInput;
    enableWhileLow = wrMode & busReq.wrData[MODE_LDE_BIT] & ~linRxInput;
    lowDetectSet   = (lowDetectEnable_q & fallEdge)
                   | enableWhileLow;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      linRxPrev_q <= RX_IDLE_RST;
    else
      linRxPrev_q <= linRxPrev_d;
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] setVec;
  logic [NUM_SRC-1:0] clrVec;
  logic [NUM_SRC-1:0] flagVec;
  logic [NUM_SRC-1:0] riseVec;

  // a written 0 clears a flag, a written 1 leaves it alone
  always_comb
  begin
    setVec = {srcEvt, lowDetectSet};
    clrVec = {NUM_SRC{wrStat}} & ~busReq.wrData[STAT_FLG_LSB +: NUM_SRC];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
      lld_flag_cell u_cell (
        .clock   (clock),
        .rst_n   (rst_n),
        .setEvt  (setVec[gi]),
        .clrEvt  (clrVec[gi]),
        .intEn   (intEnable_q[gi]),
        .flag    (flagVec[gi]),
        .riseReq (riseVec[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // aggregated request and level interrupt
  // ---------------------------------------------------------------
  logic               chanIntReq_q;
  logic               chanIntReq_d;
  logic               irq_q;
  logic               irq_d;
  logic [NUM_SRC-1:0] blocked;

  // shared line: a rising source is swallowed if any other flag stands
  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
      blocked[i] = |(flagVec & ~(NUM_SRC'(1) << i));
    chanIntReq_d = |(riseVec & ~blocked);
    irq_d        = |(flagVec & intEnable_q);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chanIntReq_q <= 1'b0;
      irq_q        <= 1'b0;
    end
    else
    begin
      chanIntReq_q <= chanIntReq_d;
      irq_q        <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe and only then
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdData_d;

  // unmapped or idle cycles read zero
  always_comb
  begin
    rdData_d = RDATA_RST;
    if (rdMode)
    begin
      rdData_d[MODE_LDE_BIT]            = lowDetectEnable_q;
      rdData_d[MODE_IEN_LSB +: NUM_SRC] = intEnable_q;
    end
    else if (rdStat)
      rdData_d[STAT_FLG_LSB +: NUM_SRC] = flagVec;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdData_q <= RDATA_RST;
    else
      rdData_q <= rdData_d;
  end

  assign rdData     = rdData_q;
  assign chanIntReq = chanIntReq_q;
  assign irq        = irq_q;

endmodule : lld_top

`default_nettype wire

// *** testbench/lld_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module lld_properties
  import lld_pkg::*;
(
  // clock, reset and register port
  input wire logic               clock,
  input wire logic               rst_n,
  input wire lld_bus_req_t       busReq,
  input wire logic [DATA_W-1:0]  rdData,
  // lin and interrupt side
  input wire logic               linRxInput,
  input wire logic [NUM_SRC-2:0] srcEvt,
  input wire logic               chanIntReq,
  input wire logic               irq
);
  // ---------------------------------------------
  // mode mirror and detect causes
  // ---------------------------------------------
  logic [4:0] mode_q;
  logic [4:0] mode_d;
  logic       rxPrev_q;
  logic       fallEv;
  logic       enWr;
  // mirror mode writes, rx history resets high so a held-low line gives an edge in the first cycle
  always_comb mode_d = (busReq.wrStb && busReq.addr == CHANNEL_MODE_REG_OFS)
    ? busReq.wrData[4:0] : mode_q;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      {mode_q, rxPrev_q} <= 6'h01;
    else
      {mode_q, rxPrev_q} <= {mode_d, linRxInput};
  assign fallEv = mode_q[0] && rxPrev_q && !linRxInput;
  assign enWr   = busReq.wrStb && busReq.addr == CHANNEL_MODE_REG_OFS
                  && busReq.wrData[0] && !linRxInput;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_reqPulse; chanIntReq |=> !chanIntReq; endproperty
  a_reqPulse: assert property (p_reqPulse) else $error("request too long");
  // irq is registered from the flags, so it trails the request by one cycle
  property p_reqIrq; chanIntReq |=> irq; endproperty
  a_reqIrq: assert property (p_reqIrq) else $error("request without irq");
  property p_reqCause; chanIntReq |-> $past(fallEv || enWr || (|srcEvt)); endproperty
  a_reqCause: assert property (p_reqCause) else $error("request without cause");
  property p_fallIrq; fallEv && mode_q[1] |-> ##[1:2] irq; endproperty
  a_fallIrq: assert property (p_fallIrq) else $error("falling edge missed");
  property p_enLow; enWr && busReq.wrData[1] |-> ##[1:2] irq; endproperty
  a_enLow: assert property (p_enLow) else $error("enable while low missed");
  property p_noEnable; (mode_q[4:1] == 4'h0) [*3] |-> !irq; endproperty
  a_noEnable: assert property (p_noEnable) else $error("irq while masked");
  property p_rdIdle; !busReq.rdStb |=> rdData == '0; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_rdMode;
    busReq.rdStb && busReq.addr == CHANNEL_MODE_REG_OFS |=> rdData == {27'h0, $past(mode_q)};
  endproperty
  a_rdMode: assert property (p_rdMode) else $error("mode readback wrong");
endmodule : lld_properties
`default_nettype wire

// *** testbench/lld_lin_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lld_lin_bus_model
(
  // dominant request from the bench
  input  wire logic dominant,
  // receive line towards the block
  output wire logic rxLine
);
  // pull-up leaves a released bus recessive high
  assign rxLine = dominant ? 1'b0 : 1'b1;
endmodule : lld_lin_bus_model
`default_nettype wire

// *** testbench/tb_lin_low_detect_wakeup.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_lin_low_detect_wakeup
  import lld_pkg::*;
;
  localparam logic [ADDR_W-1:0] MD = CHANNEL_MODE_REG_OFS;
  localparam logic [ADDR_W-1:0] ST = CHANNEL_STATUS_REG_OFS;
  logic               clock;
  logic               rst_n;
  lld_bus_req_t       busReq;
  logic [DATA_W-1:0]  rdData;
  wire                linRxInput;
  logic               dominant;
  logic [NUM_SRC-2:0] srcEvt;
  logic               chanIntReq;
  logic               irq;
  int                 errCount;
  int                 comparisons;
  int                 reqCount;
  // ---------------------------------------------
  // instances, clock and request counter
  // ---------------------------------------------
  lld_top DUT (.clock(clock), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
    .linRxInput(linRxInput), .srcEvt(srcEvt), .chanIntReq(chanIntReq), .irq(irq));
  lld_lin_bus_model bus (.dominant(dominant), .rxLine(linRxInput));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // counted on the falling edge, away from the register updates
  always @(negedge clock) if (chanIntReq === 1'b1) reqCount++;
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmpBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH t=%0t level %b exp %b", $time, got, exp);
    end
  endtask : cmpBit
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    busReq <= '0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock);
    busReq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    busReq <= '0;
    #1 cmp(rdData, exp);
  endtask : rd
  task automatic evt(input int k);
    @(posedge clock);
    srcEvt <= 3'(1 << k);
    @(posedge clock);
    srcEvt <= '0;
  endtask : evt
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // hang guard, about forty times the expected run
  initial
  begin
    repeat (3000) @(posedge clock);
    errCount++;
    give_verdict();
  end
  // ---------------------------------------------
  // wake-up preparation and detection sequence
  // ---------------------------------------------
  initial
  begin
    busReq = '0;
    dominant = 1'b0;
    srcEvt = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(MD, 32'h0);
    rd(ST, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0);
    // sleep sent in PLL speed, wake-up mode set, transceiver asleep
    // global enable off, then detect on
    wr(MD, 32'h3);
    // pending bit and priority cleared in the controller, outside this block
    rd(ST, 32'h0);
    dominant <= 1'b1;
    rd(ST, 32'h1);
    cmpBit(irq, 1'b1);
    wr(ST, 32'h1);
    rd(ST, 32'h1);
    dominant <= 1'b0;
    wr(ST, 32'h0);
    rd(ST, 32'h0);
    cmpBit(irq, 1'b0);
    // priorities, clock lowering and wait live in software
    // detect off while the line drops, then enable with the line low
    wr(MD, 32'h2);
    dominant <= 1'b1;
    rd(ST, 32'h0);
    wr(MD, 32'h3);
    rd(ST, 32'h1);
    cmp(32'(reqCount), 32'h2);
    dominant <= 1'b0;
    wr(ST, 32'h0);
    wr(MD, 32'h1f);
    for (int k = 0; k < NUM_SRC - 1; k++)
    begin
      evt(k);
      rd(ST, 32'h1 << (k + 1));
      cmp(32'(reqCount), 32'(3 + k));
      wr(ST, 32'h0);
    end
    // shared line: another flag pending hides the new request
    evt(0);
    dominant <= 1'b1;
    rd(ST, 32'h3);
    cmp(32'(reqCount), 32'h6);
    dominant <= 1'b0;
    wr(ST, 32'h0);
    wr(MD, 32'h1);
    dominant <= 1'b1;
    rd(ST, 32'h1);
    cmpBit(irq, 1'b0);
    cmp(32'(reqCount), 32'h6);
    give_verdict();
  end
endmodule : tb_lin_low_detect_wakeup
bind lld_top lld_properties u_props (.clock(clock), .rst_n(rst_n), .busReq(busReq),
  .rdData(rdData), .linRxInput(linRxInput), .srcEvt(srcEvt), .chanIntReq(chanIntReq),
  .irq(irq));
`default_nettype wire
